//--- core/ccs_command_unit.sv
`timescale 1ns/1ps
module ccs_command_unit
  import ccs_pkg::*;
(
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                rst,
  // Command port from the parser
  input  wire logic                cmdValid,
  input  wire logic [3:0]          cmdCode,
  input  wire logic [7:0]          cmdArg,
  input  wire logic [STATE_W-1:0]  setupData,
  input  wire logic                newCmdArrive,
  output logic                     cmdReady,
  output logic                     respValid,
  output logic [7:0]               respByte,
  // Bus pins, asynchronous
  input  wire logic                devClearPin,
  input  wire logic                groupTrigPin,
  input  wire logic                serialPollPin,
  output logic                     serviceReq,
  output logic                     pollValid,
  output logic [7:0]               pollByte,
  // Status summaries and operation completion
  input  wire logic                operSummary,
  input  wire logic                esbSummary,
  input  wire logic                quesSummary,
  input  wire logic                outQueueNotEmpty,
  input  wire logic                opDone,
  output logic [7:0]               statusByte,
  output logic                     clearStatus,
  output logic [7:0]               eventEnable,
  output logic                     opsPending,
  // Settings and actions towards the source
  output logic                     continuousInitiate,
  output logic                     outputOn,
  output logic                     triggerOutputLine,
  output logic [1:0]               trigSource,
  output logic [1:0]               syncSource,
  output logic [8:0]               syncPhaseAngle,
  output logic [15:0]              currentProtectionDelay,
  output logic [15:0]              trigFrequency,
  output logic                     fixedModes,
  output logic                     slewMax,
  output logic                     listStepAuto,
  output logic [12:0]              transientList,
  output logic                     calibrationOn,
  output logic                     abortTrigger,
  output logic                     busTrigger,
  output logic                     syncBusTrigger
);

  // ******************************************************************
  // State
  // ******************************************************************
  typedef struct packed {
    ccs_state_t        state;
    ccs_setup_t        setup;
    logic [7:0]        sre;
    logic [7:0]        ese;
    logic              calOn;
    logic              rqs;
    logic              mssPrev;
    logic [PEND_W-1:0] pending;
    logic              pendAny;
    logic [7:0]        stb;
    logic              cmdReady;
    logic              respValid;
    logic [7:0]        respByte;
    logic              pollValid;
    logic [7:0]        pollByte;
    logic              abortPulse;
    logic              busTrig;
    logic              syncTrig;
    logic              clrStatus;
    logic [1:0]        dclSync;
    logic [1:0]        getSync;
    logic [1:0]        pollSync;
    logic              dclPrev;
    logic              getPrev;
    logic              pollPrev;
  } ccs_unit_t;

  ccs_unit_t          r_q;
  ccs_unit_t          r_d;
  logic [STATE_W-1:0] slotRData;
  logic [7:0]         nvSre;
  logic [7:0]         nvEse;
  logic               nvPsc;
  logic               accept;
  logic               slotOk;
  logic               dclEdge;
  logic               getEdge;
  logic               pollEdge;
  logic               resetCmd;
  logic               mssNow;
  logic [7:0]         stbNow;

  // Status byte before bit six is filled in
  function automatic logic [7:0] raw_status(input logic oper,
                                            input logic esb,
                                            input logic mav,
                                            input logic ques);
    logic [7:0] b;
    b           = 8'h00;
    b[STB_OPER] = oper;
    b[STB_ESB]  = esb;
    b[STB_MAV]  = mav;
    b[STB_QUES] = ques;
    return b;
  endfunction : raw_status

  // ******************************************************************
  // Decode
  // ******************************************************************
  // Pins pass two flops; only the second flop feeds the edge detects
  assign accept   = cmdValid & r_q.cmdReady;
  assign slotOk   = (cmdArg[7:SLOT_AW] == '0);
  assign dclEdge  = r_q.dclSync[1] & ~r_q.dclPrev;
  assign getEdge  = r_q.getSync[1] & ~r_q.getPrev;
  assign pollEdge = r_q.pollSync[1] & ~r_q.pollPrev;
  assign resetCmd = dclEdge |
                    (accept & (cmdCode == CMD_RESET));

  // Summary of enabled reasons drives bit six
  always_comb begin
    stbNow = raw_status(operSummary, esbSummary,
                        outQueueNotEmpty, quesSummary);
    mssNow = |(stbNow & r_q.sre);
    stbNow[STB_MSS] = mssNow;
  end

  // ******************************************************************
  // Next state
  // ******************************************************************
  always_comb begin
    r_d            = r_q;
    r_d.respValid  = 1'b0;
    r_d.pollValid  = 1'b0;
    r_d.abortPulse = 1'b0;
    r_d.busTrig    = 1'b0;
    r_d.syncTrig   = 1'b0;
    r_d.clrStatus  = 1'b0;
    r_d.dclSync    = {r_q.dclSync[0], devClearPin};
    r_d.getSync    = {r_q.getSync[0], groupTrigPin};
    r_d.pollSync   = {r_q.pollSync[0], serialPollPin};
    r_d.dclPrev    = r_q.dclSync[1];
    r_d.getPrev    = r_q.getSync[1];
    r_d.pollPrev   = r_q.pollSync[1];
    r_d.stb        = stbNow;
    r_d.mssPrev    = mssNow;

    case (r_q.state)
      ST_POWERUP: begin
        // Masks come back from the store only when clearing is off
        r_d.sre   = nvPsc ? MASK_CLEAR : nvSre;
        r_d.ese   = nvPsc ? MASK_CLEAR : nvEse;
        r_d.state = ST_IDLE;
      end
      ST_IDLE: begin
        if (accept) begin
          case (cmdCode)
            CMD_RECALL: begin
              if (slotOk) begin
                r_d.calOn      = 1'b0;
                r_d.abortPulse = 1'b1;
                r_d.state      = ST_RECALL;
              end
            end
            CMD_SRE_WRITE:   r_d.sre = cmdArg;
            CMD_ESE_WRITE:   r_d.ese = cmdArg;
            CMD_SETUP_WRITE: r_d.setup = ccs_setup_t'(setupData);
            CMD_CLEAR_STATUS: r_d.clrStatus = 1'b1;
            CMD_SRE_QUERY: begin
              r_d.respValid = 1'b1;
              r_d.respByte  = r_q.sre;
            end
            CMD_PSC_QUERY: begin
              r_d.respValid = 1'b1;
              r_d.respByte  = {7'h00, nvPsc};
            end
            CMD_STB_QUERY: begin
              // Read only: nothing in the byte is cleared here
              r_d.respValid = 1'b1;
              r_d.respByte  = stbNow;
            end
            CMD_WAIT: begin
              if (r_q.pending != '0) begin
                r_d.state = ST_WAIT;
              end
            end
            CMD_OVERLAPPED: r_d.calOn = setupData[0];
            default: ;
          endcase
        end
      end
      ST_RECALL: begin
        r_d.setup = ccs_setup_t'(slotRData);
        r_d.state = ST_IDLE;
      end
      ST_WAIT: begin
        if (r_q.pending == '0 || newCmdArrive) begin
          r_d.state = ST_IDLE;
        end
      end
      default: r_d.state = ST_IDLE;
    endcase

    // Overlapped work is counted, not waited on, unless a wait is due
    if (accept && cmdCode == CMD_OVERLAPPED && !opDone &&
        r_q.pending != '1) begin
      r_d.pending = r_q.pending + 1'b1;
    end else if (opDone && !(accept && cmdCode == CMD_OVERLAPPED) &&
                 r_q.pending != '0) begin
      r_d.pending = r_q.pending - 1'b1;
    end
    // Registered so the pending flag leaves the block from a flop
    r_d.pendAny = (r_d.pending != '0);

    // Device clear wins over a setup write or a recall load taken in the same cycle
    if (resetCmd) begin
      r_d.setup = SETUP_DEFAULT;
      r_d.setup.transientList = r_q.setup.transientList;
      r_d.clrStatus = 1'b1;
    end

    // Trigger to every bus-sourced subsystem
    if (getEdge || (accept && cmdCode == CMD_TRIGGER)) begin
      r_d.busTrig  = (r_q.setup.trigSource == SRC_BUS);
      r_d.syncTrig = (r_q.setup.syncSource == SRC_BUS);
    end

    // Serial poll answers with the request flag in bit six
    if (pollEdge) begin
      r_d.pollValid         = 1'b1;
      r_d.pollByte          = stbNow;
      r_d.pollByte[STB_MSS] = r_q.rqs;
    end

    // A new reason sets the flag even in the poll's own cycle
    r_d.rqs = ((r_q.rqs & ~pollEdge) |
               (mssNow & ~r_q.mssPrev)) & mssNow;
    r_d.cmdReady = (r_d.state == ST_IDLE);
  end

  // ******************************************************************
  // Registers
  // ******************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      r_q          <= '0;
      r_q.state    <= ST_POWERUP;
      r_q.setup    <= SETUP_DEFAULT;
      r_q.clrStatus <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // Saved slots and nonvolatile masks
  ccs_state_store #(
    .WIDTH (STATE_W),
    .SLOTS (SLOT_COUNT)
  ) u_store (
    .clock     (clock),
    .slotWe    (accept && cmdCode == CMD_SAVE && slotOk),
    .slotWAddr (cmdArg[SLOT_AW-1:0]),
    .slotWData (r_q.setup),
    .slotRAddr (cmdArg[SLOT_AW-1:0]),
    .slotRData (slotRData),
    .sreWe     (accept && cmdCode == CMD_SRE_WRITE),
    .eseWe     (accept && cmdCode == CMD_ESE_WRITE),
    .pscWe     (accept && cmdCode == CMD_PSC_WRITE),
    .maskIn    (cmdArg),
    .pscIn     (cmdArg[0]),
    .nvSre     (nvSre),
    .nvEse     (nvEse),
    .nvPsc     (nvPsc)
  );

  // Outputs, all taken from flops
  assign cmdReady               = r_q.cmdReady;
  assign respValid              = r_q.respValid;
  assign respByte               = r_q.respByte;
  assign serviceReq             = r_q.rqs;
  assign pollValid              = r_q.pollValid;
  assign pollByte               = r_q.pollByte;
  assign statusByte             = r_q.stb;
  assign clearStatus            = r_q.clrStatus;
  assign eventEnable            = r_q.ese;
  assign opsPending             = r_q.pendAny;
  assign continuousInitiate     = r_q.setup.contInit;
  assign outputOn               = r_q.setup.outputOn;
  assign triggerOutputLine      = r_q.setup.trigOutLine;
  assign trigSource             = r_q.setup.trigSource;
  assign syncSource             = r_q.setup.syncSource;
  assign syncPhaseAngle         = r_q.setup.syncPhase;
  assign currentProtectionDelay = r_q.setup.curProtDelay;
  assign trigFrequency          = r_q.setup.trigFrequency;
  assign fixedModes             = r_q.setup.fixedModes;
  assign slewMax                = r_q.setup.slewMax;
  assign listStepAuto           = r_q.setup.listStepAuto;
  assign transientList          = r_q.setup.transientList;
  assign calibrationOn          = r_q.calOn;
  assign abortTrigger           = r_q.abortPulse;
  assign busTrigger             = r_q.busTrig;
  assign syncBusTrigger         = r_q.syncTrig;

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  recall_restore_a: assert property (
    r_q.state == ST_RECALL && !resetCmd
    |=> r_q.setup == $past(slotRData))
    else $error("recall did not restore slot");
  recall_abort_a: assert property (
    accept && cmdCode == CMD_RECALL && slotOk && !dclEdge
    |=> !r_q.calOn && r_q.abortPulse ##1 r_q.state == ST_IDLE)
    else $error("recall left calibration or trigger");
  reset_defaults_a: assert property (
    resetCmd |=> r_q.setup.curProtDelay == 16'h0064 &&
    r_q.setup.trigFrequency == 16'h003C && !r_q.setup.outputOn)
    else $error("reset defaults wrong");
  reset_keeps_mask_a: assert property (
    resetCmd && r_q.state == ST_IDLE && !accept
    |=> r_q.sre == $past(r_q.sre) && r_q.clrStatus)
    else $error("reset touched enable mask");
  zero_mask_a: assert property (
    r_q.sre == 8'h00 |=> !serviceReq)
    else $error("service request with zero mask");
  poll_clear_a: assert property (
    pollEdge && !(mssNow && !r_q.mssPrev)
    |=> !r_q.rqs && r_q.pollValid && r_q.stb[6] == $past(mssNow))
    else $error("poll did not clear request flag");
  stb_query_a: assert property (
    accept && cmdCode == CMD_STB_QUERY
    |=> respValid && respByte == $past(stbNow))
    else $error("status query answer wrong");
  bus_trigger_a: assert property (
    accept && cmdCode == CMD_TRIGGER && r_q.setup.trigSource == SRC_BUS
    |=> busTrigger)
    else $error("bus trigger missing");
  wait_hold_a: assert property (
    r_q.state == ST_WAIT && r_q.pending != '0 && !newCmdArrive
    |=> !cmdReady)
    else $error("wait released early");
  powerup_mask_a: assert property (
    r_q.state == ST_POWERUP && nvPsc |=> r_q.sre == 8'h00 &&
    r_q.ese == 8'h00 ##1 cmdReady)
    else $error("power-on masks not cleared");

endmodule : ccs_command_unit

//--- include/ccs_pkg.sv
// ********************************************************************
// Common command and status unit: shared constants and types
// ********************************************************************
package ccs_pkg;

  // Sizes of the saved state and of the slot store
  localparam int STATE_W    = 64;
  localparam int SLOT_COUNT = 8;
  localparam int SLOT_AW    = 3;
  localparam int PEND_W     = 4;

  // Command codes presented by the command parser
  typedef enum logic [3:0] {
    CMD_NOP          = 4'h0,
    CMD_RECALL       = 4'h1,
    CMD_SAVE         = 4'h2,
    CMD_RESET        = 4'h3,
    CMD_CLEAR_STATUS = 4'h4,
    CMD_SRE_WRITE    = 4'h5,
    CMD_SRE_QUERY    = 4'h6,
    CMD_STB_QUERY    = 4'h7,
    CMD_ESE_WRITE    = 4'h8,
    CMD_PSC_WRITE    = 4'h9,
    CMD_PSC_QUERY    = 4'hA,
    CMD_TRIGGER      = 4'hB,
    CMD_WAIT         = 4'hC,
    CMD_SETUP_WRITE  = 4'hD,
    CMD_OVERLAPPED   = 4'hE,
    CMD_SEQUENTIAL   = 4'hF
  } ccs_cmd_t;

  // Trigger and sync source encodings
  localparam logic [1:0] SRC_IMMEDIATE = 2'h0;
  localparam logic [1:0] SRC_BUS       = 2'h1;
  localparam logic [1:0] SRC_EXTERNAL  = 2'h2;

  // Status summary byte bit positions
  localparam int STB_OPER = 7;
  localparam int STB_MSS  = 6;
  localparam int STB_ESB  = 5;
  localparam int STB_MAV  = 4;
  localparam int STB_QUES = 3;

  // Factory default values of the settings
  localparam logic [15:0] CUR_PROT_DELAY_MS = 16'h0064;
  localparam logic [15:0] TRIG_FREQ_HZ      = 16'h003C;
  localparam logic [8:0]  SYNC_PHASE_DEG    = 9'h000;
  localparam logic [7:0]  MASK_CLEAR        = 8'h00;

  // Settings word that is saved, recalled and, but for transientList, reset
  typedef struct packed {
    logic [12:0] transientList;
    logic        listStepAuto;
    logic [15:0] trigFrequency;
    logic [15:0] curProtDelay;
    logic [8:0]  syncPhase;
    logic        slewMax;
    logic        fixedModes;
    logic [1:0]  syncSource;
    logic [1:0]  trigSource;
    logic        trigOutLine;
    logic        outputOn;
    logic        contInit;
  } ccs_setup_t;

  localparam ccs_setup_t SETUP_DEFAULT = '{
    transientList: 13'h0000,
    listStepAuto:  1'h1,
    trigFrequency: TRIG_FREQ_HZ,
    curProtDelay:  CUR_PROT_DELAY_MS,
    syncPhase:     SYNC_PHASE_DEG,
    slewMax:       1'h1,
    fixedModes:    1'h1,
    syncSource:    SRC_IMMEDIATE,
    trigSource:    SRC_IMMEDIATE,
    trigOutLine:   1'h0,
    outputOn:      1'h0,
    contInit:      1'h0
  };

  // Control states, one-hot
  typedef enum logic [3:0] {
    ST_POWERUP = 4'h1,
    ST_IDLE    = 4'h2,
    ST_RECALL  = 4'h4,
    ST_WAIT    = 4'h8
  } ccs_state_t;

endpackage : ccs_pkg

//--- core/ccs_state_store.sv
`timescale 1ns/1ps
// ********************************************************************
// Nonvolatile store: eight setting slots and the enable masks
// ********************************************************************
module ccs_state_store
  import ccs_pkg::*;
#(
  parameter int WIDTH = STATE_W,
  parameter int SLOTS = SLOT_COUNT
) (
  // Clock
  input  wire logic                     clock,
  // Slot write and read
  input  wire logic                     slotWe,
  input  wire logic [SLOT_AW-1:0]       slotWAddr,
  input  wire logic [WIDTH-1:0]         slotWData,
  input  wire logic [SLOT_AW-1:0]       slotRAddr,
  output logic      [WIDTH-1:0]         slotRData,
  // Nonvolatile enable masks and clear setting
  input  wire logic                     sreWe,
  input  wire logic                     eseWe,
  input  wire logic                     pscWe,
  input  wire logic [7:0]               maskIn,
  input  wire logic                     pscIn,
  output logic      [7:0]               nvSre,
  output logic      [7:0]               nvEse,
  output logic                          nvPsc
);

  typedef struct packed {
    logic [WIDTH-1:0] rdata;
    logic [7:0]       sre;
    logic [7:0]       ese;
    logic             psc;
  } ccs_nv_t;

  // Contents survive reset on purpose; they model nonvolatile cells
  ccs_nv_t          q = '{rdata: '0, sre: 8'h00, ese: 8'h00, psc: 1'h1};
  ccs_nv_t          d;
  logic [WIDTH-1:0] slotMem [SLOTS] = '{default: '0};

  // Next value of the mask copies and the read port
  always_comb begin
    d       = q;
    d.rdata = slotMem[slotRAddr];
    if (sreWe) begin
      d.sre = maskIn;
    end
    if (eseWe) begin
      d.ese = maskIn;
    end
    if (pscWe) begin
      d.psc = pscIn;
    end
  end

  // Registered read keeps the array a plain synchronous RAM
  always_ff @(posedge clock) begin
    q <= d;
    if (slotWe) begin
      slotMem[slotWAddr] <= slotWData;
    end
  end

  assign slotRData = q.rdata;
  assign nvSre     = q.sre;
  assign nvEse     = q.ese;
  assign nvPsc     = q.psc;

endmodule : ccs_state_store

//--- bench/ccs_bus_host.sv
`timescale 1ns/1ps
// ********************************************************************
// Remote bus controller: pin strobes and serial poll capture
// ********************************************************************
module ccs_bus_host (
  // Clock
  input  wire logic       clock,
  // Poll answer from the device
  input  wire logic       pollValid,
  input  wire logic [7:0] pollByte,
  // Bus pins towards the device
  output logic            devClearPin,
  output logic            groupTrigPin,
  output logic            serialPollPin,
  // Last byte returned by a poll
  output logic [7:0]      lastPoll
);
  // Pins rest low from time zero
  initial begin
    {devClearPin, groupTrigPin, serialPollPin} = 3'h0;
  end

  // Poll valid stands one cycle only, so catch the byte on that edge
  always @(posedge clock) begin
    if (pollValid) lastPoll <= pollByte;
  end

  // Held high and low three clocks each: the sync needs two at least
  task automatic strobe(input int w);
    @(negedge clock);
    case (w)
      0: devClearPin = 1'b1;
      1: groupTrigPin = 1'b1;
      default: serialPollPin = 1'b1;
    endcase
    repeat (3) @(negedge clock);
    {devClearPin, groupTrigPin, serialPollPin} = 3'h0;
    repeat (3) @(negedge clock);
  endtask : strobe
endmodule : ccs_bus_host

//--- bench/ccs_command_unit_tb_top.sv
`timescale 1ns/1ps
// ********************************************************************
// Bench for the common command and status unit
// ********************************************************************
module ccs_command_unit_tb_top;
  import ccs_pkg::*;
  // Stimulus, settled at time zero
  logic        clock = 1'b0, rst = 1'b1, cmdValid = 1'b0;
  logic        newCmdArrive = 1'b0, opDone = 1'b0;
  logic [3:0]  cmdCode = 4'h0;
  logic [7:0]  cmdArg = 8'h00;
  logic [63:0] setupData = 64'h0;
  logic        operSummary = 1'b0, esbSummary = 1'b0;
  logic        quesSummary = 1'b0, outQueueNotEmpty = 1'b0;
  // Observed outputs
  logic        cmdReady, respValid, serviceReq, pollValid, clearStatus;
  logic        opsPending, continuousInitiate, outputOn, triggerOutputLine;
  logic        fixedModes, slewMax, listStepAuto, calibrationOn;
  logic        abortTrigger, busTrigger, syncBusTrigger;
  logic        devClearPin, groupTrigPin, serialPollPin;
  logic [7:0]  respByte, pollByte, statusByte, eventEnable, lastPoll;
  logic [1:0]  trigSource, syncSource;
  logic [8:0]  syncPhaseAngle;
  logic [15:0] currentProtectionDelay, trigFrequency;
  logic [12:0] transientList;
  ccs_setup_t  live, e;
  logic [3:0]  w;
  int          fail_count = 0, total_checks = 0, trigCnt = 0, clrCnt = 0;
  int          t0;

  // Settings outputs packed back into one word
  assign live = {transientList, listStepAuto, trigFrequency,
                 currentProtectionDelay, syncPhaseAngle, slewMax,
                 fixedModes, syncSource, trigSource, triggerOutputLine,
                 outputOn, continuousInitiate};

  // Clock and pulse counters
  always #5 clock = ~clock;
  always @(posedge clock) begin
    trigCnt <= trigCnt + busTrigger + syncBusTrigger;
    clrCnt <= clrCnt + clearStatus;
  end

  ccs_command_unit ccs_command_unit_i (.clock, .rst, .cmdValid, .cmdCode,
    .cmdArg, .setupData, .newCmdArrive, .cmdReady, .respValid, .respByte,
    .devClearPin, .groupTrigPin, .serialPollPin, .serviceReq, .pollValid,
    .pollByte, .operSummary, .esbSummary, .quesSummary, .outQueueNotEmpty,
    .opDone, .statusByte, .clearStatus, .eventEnable, .opsPending,
    .continuousInitiate, .outputOn, .triggerOutputLine, .trigSource,
    .syncSource, .syncPhaseAngle, .currentProtectionDelay, .trigFrequency,
    .fixedModes, .slewMax, .listStepAuto, .transientList, .calibrationOn,
    .abortTrigger, .busTrigger, .syncBusTrigger);
  ccs_bus_host ccs_bus_host_i (.clock, .pollValid, .pollByte, .devClearPin,
    .groupTrigPin, .serialPollPin, .lastPoll);

  // Comparison and verdict
  task automatic chk(input string n, input logic [63:0] s,
                     input logic [63:0] x);
    total_checks++;
    if (s !== x) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // Command held until taken; returns half a cycle after the taking edge
  task automatic cmd(input ccs_cmd_t c, input logic [7:0] a);
    int n;
    n = 0;
    @(negedge clock);
    cmdValid = 1'b1;
    cmdCode = c;
    cmdArg = a;
    while (cmdReady !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    // A command never taken counts as a mismatch
    chk("cmd taken", cmdReady, 1'b1);
    @(negedge clock);
    cmdValid = 1'b0;
  endtask : cmd
  task automatic put(input ccs_setup_t v);
    setupData = v;
    cmd(CMD_SETUP_WRITE, 8'h00);
  endtask : put
  task automatic pulse(ref logic p);
    @(negedge clock);
    p = 1'b1;
    @(negedge clock);
    p = 1'b0;
  endtask : pulse
  task automatic reset3;
    @(negedge clock);
    rst = 1'b1;
    repeat (3) @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
  endtask : reset3
  function automatic ccs_setup_t mk(input logic [2:0] s);
    mk = SETUP_DEFAULT;
    mk.transientList = {10'h155, s};
    mk.trigSource = SRC_BUS;
    mk.syncSource = SRC_BUS;
    mk.syncPhase = 9'h05A;
    mk.outputOn = 1'b1;
    mk.curProtDelay = {13'h0, s};
  endfunction : mk

  // Hang guard, far beyond the 150 or so cycles the tests need
  initial begin
    #100000;
    fail_count++;
    final_report;
  end

  // ******************************************************************
  // Test sequence
  // ******************************************************************
  initial begin
    reset3;
    chk("defaults", live, SETUP_DEFAULT);
    chk("delay freq", {currentProtectionDelay, trigFrequency},
        32'h0064003C);
    chk("ese at power-on", eventEnable, 8'h00);
    // Boundary slots saved, then recalled over other settings
    put(mk(3'h0));
    cmd(CMD_SAVE, 8'h00);
    put(mk(3'h7));
    cmd(CMD_SAVE, 8'h07);
    setupData = 64'h1;
    cmd(CMD_OVERLAPPED, 8'h00);
    chk("cal on", calibrationOn, 1'b1);
    pulse(opDone);
    cmd(CMD_RECALL, 8'h00);
    chk("abort", abortTrigger, 1'b1);
    chk("cal off", calibrationOn, 1'b0);
    @(negedge clock);
    chk("recall 0", live, mk(3'h0));
    cmd(CMD_RECALL, 8'h07);
    @(negedge clock);
    chk("recall 7", live, mk(3'h7));
    cmd(CMD_RECALL, 8'h08);
    @(negedge clock);
    chk("recall 8", live, mk(3'h7));
    // Reset command and device clear load the defaults; the reset command keeps the event mask
    cmd(CMD_ESE_WRITE, 8'hA5);
    e = SETUP_DEFAULT;
    e.transientList = mk(3'h7).transientList;
    t0 = clrCnt;
    cmd(CMD_RESET, 8'h00);
    @(negedge clock);
    chk("reset", live, e);
    chk("reset clear", clrCnt - t0, 1);
    chk("reset ese", eventEnable, 8'hA5);
    put(mk(3'h7));
    t0 = clrCnt;
    ccs_bus_host_i.strobe(0);
    chk("dev clear", live, e);
    chk("dev clear st", clrCnt - t0, 1);
    // Each summary source reaches its bit and the request bit
    cmd(CMD_SRE_WRITE, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      w = 4'h8 >> i;
      {operSummary, esbSummary, outQueueNotEmpty, quesSummary} = w;
      repeat (3) @(negedge clock);
      chk("stb", statusByte,
          {w[3], 1'b1, w[2:0], 3'h0});
      chk("srq", serviceReq, 1'b1);
    end
    repeat (2) begin
      cmd(CMD_STB_QUERY, 8'h00);
      chk("stb query", {respValid, respByte}, 9'h148);
    end
    // First poll carries the request flag, second does not
    ccs_bus_host_i.strobe(2);
    chk("poll 1", lastPoll, 8'h48);
    chk("srq after poll", serviceReq, 1'b0);
    chk("mss after poll", statusByte, 8'h48);
    ccs_bus_host_i.strobe(2);
    chk("poll 2", lastPoll, 8'h08);
    // Masked sources raise nothing
    {operSummary, quesSummary} = 2'b10;
    cmd(CMD_SRE_WRITE, 8'h20);
    repeat (2) @(negedge clock);
    chk("masked", {serviceReq, statusByte}, 9'h080);
    {operSummary, esbSummary, outQueueNotEmpty, quesSummary} = 4'hF;
    cmd(CMD_SRE_WRITE, 8'h00);
    repeat (3) @(negedge clock);
    chk("zero mask", {serviceReq, statusByte}, 9'h0B8);
    {operSummary, esbSummary, outQueueNotEmpty, quesSummary} = 4'h0;
    // Command and pin triggers with a bus trigger source
    put(mk(3'h7));
    t0 = trigCnt;
    cmd(CMD_TRIGGER, 8'h00);
    ccs_bus_host_i.strobe(1);
    // Trigger and sync both sourced from the bus: two pulses per trigger
    chk("triggers", trigCnt - t0, 4);
    // Wait released by completion, then abandoned by a new command
    setupData = 64'h0;
    cmd(CMD_OVERLAPPED, 8'h00);
    cmd(CMD_WAIT, 8'h00);
    repeat (3) @(negedge clock);
    chk("wait holds", {cmdReady, opsPending}, 2'b01);
    pulse(opDone);
    repeat (2) @(negedge clock);
    chk("wait done", {cmdReady, opsPending}, 2'b10);
    cmd(CMD_OVERLAPPED, 8'h00);
    cmd(CMD_WAIT, 8'h00);
    pulse(newCmdArrive);
    repeat (2) @(negedge clock);
    chk("wait dropped", {cmdReady, opsPending}, 2'b11);
    pulse(opDone);
    // Stored masks come back only while the clear setting is off
    cmd(CMD_PSC_WRITE, 8'h00);
    cmd(CMD_SRE_WRITE, 8'h42);
    cmd(CMD_ESE_WRITE, 8'h3C);
    reset3;
    cmd(CMD_SRE_QUERY, 8'h00);
    chk("kept sre", {respByte, eventEnable}, 16'h423C);
    cmd(CMD_PSC_WRITE, 8'h01);
    reset3;
    cmd(CMD_SRE_QUERY, 8'h00);
    chk("cleared", {respByte, eventEnable}, 16'h0000);
    // Clear setting query and the explicit clear-status command
    cmd(CMD_PSC_QUERY, 8'h00);
    chk("psc query", {respValid, respByte}, 9'h101);
    t0 = clrCnt;
    cmd(CMD_CLEAR_STATUS, 8'h00);
    @(negedge clock);
    chk("clear cmd", clrCnt - t0, 1);
    final_report;
  end
endmodule : ccs_command_unit_tb_top
